// [design/trr_reader.sv]
// Summary of operation
// - One input line carries run and stop levels
// - External mode slews while run held high
// - Self stop halts on next sprocket after run
// - Each run pulse steps exactly one character
// - Data outputs gated by sprocket or ungated
// - One direction, slew at 100/200/300 cps
// - Stop settles in about one millisecond
// - First character after pinch time plus character
// - Five to eight channels, hole versus no hole
// - Run present at self stop keeps slewing
`timescale 1ns/1ps
`default_nettype none
`include "trr_consts.svh"

module trr_reader #(
   parameter int unsigned CHANNELS  = `TRR_MAX_CHAN,
   parameter int unsigned STOP_CYC  = `TRR_STOP_CYC,
   parameter int unsigned PINCH_CYC = `TRR_PINCH_CYC,
   parameter int unsigned CLK_HZ    = `TRR_CLK_KHZ * 1000
) (
   input  wire logic                core_clk_in,
   input  wire logic                nrst_in,
   input  wire logic                run_stop_in,
   input  wire logic                self_stop_in,
   input  wire logic                gated_in,
   input  wire logic [1:0]          speed_in,
   input  wire logic [CHANNELS-1:0] head_chan_in,
   input  wire logic                head_sprocket_in,
   output logic                     tape_moving_out,
   output logic                     pinch_out,
   output logic                     brake_out,
   output logic [CHANNELS-1:0]      data_out,
   output logic                     sprocket_pulse_out
);
   localparam int unsigned CW = 32;

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic [CHANNELS+2:0] s1_q, s2_q, s1_d, s2_d;
   logic                run_s, spr_s;
   logic [CHANNELS-1:0] chan_s;

   // Two stages; only the second stage is read by logic
   always_comb begin
      s1_d = {run_stop_in, head_sprocket_in, 1'b0, head_chan_in};
      s2_d = s1_q;
   end
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end
   assign run_s  = s2_q[CHANNELS+2];
   assign spr_s  = s2_q[CHANNELS+1];
   assign chan_s = s2_q[CHANNELS-1:0];

   // -----------------------------------------------------------------
   // Run and sprocket edge history
   // -----------------------------------------------------------------
   logic run_prev_q, run_prev_d, spr_prev_q, spr_prev_d;
   logic run_rise, spr_rise;
   always_comb begin
      run_prev_d = run_s;
      spr_prev_d = spr_s;
   end
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         run_prev_q <= 1'b0;
         spr_prev_q <= 1'b0;
      end else begin
         run_prev_q <= run_prev_d;
         spr_prev_q <= spr_prev_d;
      end
   end
   assign run_rise = run_s & ~run_prev_q;
   assign spr_rise = spr_s & ~spr_prev_q;

   // -----------------------------------------------------------------
   // Character time per standard speed
   // -----------------------------------------------------------------
   logic [CW-1:0] char_cyc;
   always_comb begin
      unique case (speed_in)
         `TRR_SPEED_100: char_cyc = CW'(CLK_HZ / `TRR_CPS_100);
         `TRR_SPEED_200: char_cyc = CW'(CLK_HZ / `TRR_CPS_200);
         default:        char_cyc = CW'(CLK_HZ / `TRR_CPS_300);
      endcase
   end

   // -----------------------------------------------------------------
   // Transport state machine
   // -----------------------------------------------------------------
   trr_pkg::trr_state_t st_q, st_d;
   logic [CW-1:0]       cnt_q, cnt_d;
   logic                pend_q, pend_d;  // Stop armed by a run pulse
   logic                want_stop;

   // Self stop on sprocket unless run is still present; external
   // mode stops on the stop level alone.
   always_comb begin
      if (self_stop_in)
         want_stop = spr_rise & ~run_s & pend_q;
      else
         want_stop = ~run_s;
   end

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      pend_d = pend_q;
      if (run_rise || (run_s && st_q != trr_pkg::TRR_STOPPED))
         pend_d = 1'b1;
      unique case (st_q)
         trr_pkg::TRR_STOPPED: begin
            if (run_s) begin
               st_d  = trr_pkg::TRR_STARTING;
               cnt_d = CW'(PINCH_CYC) + char_cyc;
            end
         end
         trr_pkg::TRR_STARTING, trr_pkg::TRR_SLEWING: begin
            if (st_q == trr_pkg::TRR_STARTING) begin
               if (cnt_q != '0)
                  cnt_d = cnt_q - CW'(1);
               else
                  st_d = trr_pkg::TRR_SLEWING;
            end
            if (want_stop) begin
               st_d   = trr_pkg::TRR_BRAKING;
               cnt_d  = CW'(STOP_CYC);
               pend_d = 1'b0;
            end
         end
         trr_pkg::TRR_BRAKING: begin
            if (cnt_q != '0)
               cnt_d = cnt_q - CW'(1);
            else
               st_d = trr_pkg::TRR_STOPPED;
         end
      endcase
   end
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         st_q   <= trr_pkg::TRR_STOPPED;
         cnt_q  <= '0;
         pend_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         pend_q <= pend_d;
      end
   end

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   logic                mov_d, pin_d, brk_d, sp_d;
   logic [CHANNELS-1:0] dat_d;
   // Tape only ever runs forward, so there is no direction output
   always_comb begin
      pin_d = (st_d == trr_pkg::TRR_STARTING) ||
              (st_d == trr_pkg::TRR_SLEWING);
      brk_d = ~pin_d;
      mov_d = pin_d || (st_d == trr_pkg::TRR_BRAKING);
      sp_d  = spr_s;
      // Gated mode hides data outside the sprocket window
      dat_d = (gated_in && !spr_s) ? '0 : chan_s;
   end
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         tape_moving_out    <= 1'b0;
         pinch_out          <= 1'b0;
         brake_out          <= 1'b1;
         sprocket_pulse_out <= 1'b0;
         data_out           <= '0;
      end else begin
         tape_moving_out    <= mov_d;
         pinch_out          <= pin_d;
         brake_out          <= brk_d;
         sprocket_pulse_out <= sp_d;
         data_out           <= dat_d;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_self_stop;
      self_stop_in && spr_rise && !run_s && pend_q &&
      (st_q == trr_pkg::TRR_SLEWING);
   endsequence

   AST_SELF_STOP: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in) s_self_stop |=> st_q == trr_pkg::TRR_BRAKING)
      else $error("self stop did not brake");
   AST_RUN_HOLDS: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in)
      (self_stop_in && run_s && st_q == trr_pkg::TRR_SLEWING)
      |=> st_q != trr_pkg::TRR_BRAKING)
      else $error("stopped while run present");
   AST_EXT_STOP: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in)
      (!self_stop_in && !run_s && st_q == trr_pkg::TRR_SLEWING)
      |=> st_q == trr_pkg::TRR_BRAKING)
      else $error("external stop ignored");
   AST_GATED: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in)
      ($past(gated_in) && !sprocket_pulse_out) |-> data_out == '0)
      else $error("gated data leaked");
   AST_SPROCKET: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in) sprocket_pulse_out == $past(spr_s))
      else $error("sprocket misaligned");
   AST_BRAKE: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in) pinch_out |-> !brake_out)
      else $error("pinch and brake together");
   AST_START: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in)
      (st_q == trr_pkg::TRR_STOPPED && run_s)
      |=> st_q == trr_pkg::TRR_STARTING)
      else $error("run level did not start tape");
   AST_STEP_ARM: assert property (@(posedge core_clk_in)
      disable iff (!nrst_in) run_rise |=> pend_q)
      else $error("run pulse not armed");
endmodule
`default_nettype wire

// [design/trr_consts.svh]
`ifndef TRR_CONSTS_SVH
`define TRR_CONSTS_SVH
// Clock rate in kHz (250 MHz)
`define TRR_CLK_KHZ        250000
// Stop settle time in microseconds
`define TRR_STOP_US        1000
// Pinch roller operate time in microseconds
`define TRR_PINCH_US       3000
// Least run pulse width in nanoseconds
`define TRR_RUN_MIN_NS     5000
// Cycles derived from the times above
`define TRR_STOP_CYC       ((`TRR_STOP_US * `TRR_CLK_KHZ) / 1000)
`define TRR_PINCH_CYC      ((`TRR_PINCH_US * `TRR_CLK_KHZ) / 1000)
`define TRR_RUN_MIN_CYC    ((`TRR_RUN_MIN_NS * `TRR_CLK_KHZ + 999999) / 1000000)
// Standard slew speed codes, characters per second
`define TRR_SPEED_100      2'h0
`define TRR_SPEED_200      2'h1
`define TRR_SPEED_300      2'h2
`define TRR_CPS_100        100
`define TRR_CPS_200        200
`define TRR_CPS_300        300
// Channel count limits
`define TRR_MIN_CHAN       5
`define TRR_MAX_CHAN       8
`endif

// [design/trr_pkg.sv]
`default_nettype none
package trr_pkg;
   typedef enum logic [1:0] {
      TRR_STOPPED,
      TRR_STARTING,
      TRR_SLEWING,
      TRR_BRAKING
   } trr_state_t;
endpackage
`default_nettype wire

// [bench/trr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Controlling equipment on the run line
// ----------------------------------------
module trr_host_model #(
   parameter int PULSE_CYC = 5
) (
   input  wire logic clk_in,
   input  wire logic level_in,
   input  wire logic step_in,
   output logic      run_stop_out
);
   int cnt_q = 0;
   // Fixed pulse width, far shorter than one character step
   always @(posedge clk_in) begin
      if (step_in) cnt_q <= PULSE_CYC;
      else if (cnt_q > 0) cnt_q <= cnt_q - 1;
   end
   // High runs, low stops, both on the one line
   assign run_stop_out = level_in | (cnt_q > 0);
endmodule
`default_nettype wire

// [bench/tape_reader_run_stop_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Tape, host and scenarios
// ----------------------------------------
module tape_reader_run_stop_control_test;
   logic       clk = 1'h0, nrst = 1'h0, self_s = 1'h0, gated = 1'h0;
   logic       lvl = 1'h0, step = 1'h0, sprk = 1'h0, spo_q = 1'h0;
   logic       drop, win, run, mov, pin, brk, spo;
   logic [1:0] spd = 2'h0;
   logic [7:0] chan = 8'h00, last = 8'h00, data;
   int         tpos = 0, spk = 0, n, cyc = 0;
   int         err_total = 0, samples_checked = 0;
   always #2 clk = ~clk;
   trr_reader #(.STOP_CYC(10), .PINCH_CYC(20), .CLK_HZ(3000)) u_dut (
      .core_clk_in(clk), .nrst_in(nrst), .run_stop_in(run),
      .self_stop_in(self_s), .gated_in(gated), .speed_in(spd),
      .head_chan_in(chan), .head_sprocket_in(sprk),
      .tape_moving_out(mov), .pinch_out(pin), .brake_out(brk),
      .data_out(data), .sprocket_pulse_out(spo));
   trr_host_model u_host (.clk_in(clk), .level_in(lvl), .step_in(step),
      .run_stop_out(run));
   // Tape coasts while braking, so it never parks on a sprocket
   assign win = mov && tpos % 40 >= 20 && tpos % 40 < 24;
   always @(negedge clk) begin
      if (mov) tpos <= tpos + 1;
      sprk <= win;
      chan <= win ? 8'(tpos / 40 + 1) : ~last;
      if (sprk) last <= chan;
      spo_q <= spo;
      if (spo && !spo_q) begin
         spk <= spk + 1;
         chk("char data", data, last);
      end
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total = err_total + 1;
         end_sim();
      end
   end
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic stp();
      step = 1'h1;
      @(negedge clk);
      step = 1'h0;
   endtask
   task automatic wait_pin(input logic v);
      for (n = 0; n < 12 && pin !== v; n++) @(negedge clk);
      chk("pinch", pin, v);
   endtask
   task automatic wait_mov();
      for (n = 0; n < 400 && mov !== 1'h0; n++) @(negedge clk);
      chk("halted", {mov, brk}, 8'h01);
   endtask
   task automatic t_ext();
      lvl = 1'h1;
      wait_pin(1'h1);
      spk = 0;
      repeat (200) @(negedge clk);
      chk("slewing", pin & (spk > 3), 8'h01);
      lvl = 1'h0;
      wait_pin(1'h0);
      wait_mov();
      chk("brake time", 8'(n), 8'h0b);
      $display("external control done");
   endtask
   task automatic t_lvl();
      self_s = 1'h1;
      lvl = 1'h1;
      wait_pin(1'h1);
      spk = 0;
      for (n = 0; n < 200 && spk < 2; n++) @(negedge clk);
      spk = 0;
      lvl = 1'h0;
      wait_mov();
      chk("stop on next char", 8'(spk), 8'h01);
      $display("self stop level done");
   endtask
   task automatic t_step();
      for (int s = 0; s < 3; s++) begin
         spd = 2'(s);
         spk = 0;
         stp();
         wait_pin(1'h1);
         wait_mov();
         chk("one char per pulse", 8'(spk), 8'h01);
      end
      $display("stepping done");
   endtask
   task automatic t_keep();
      drop = 1'h0;
      spk = 0;
      stp();
      wait_pin(1'h1);
      repeat (3) begin
         for (n = 0; n < 99 && tpos % 40 != 17; n++) begin
            drop = drop | !pin;
            @(negedge clk);
         end
         stp();
      end
      wait_mov();
      chk("run keeps slewing", {drop, 7'(spk)}, 8'h04);
      $display("run at stop done");
   endtask
   task automatic t_gate();
      repeat (4) @(negedge clk);
      chk("ungated idle", data, ~last);
      gated = 1'h1;
      repeat (4) @(negedge clk);
      stp();
      for (n = 0; n < 90; n++) begin
         if (spo === 1'h0) chk("gated data", data, 8'h00);
         @(negedge clk);
      end
      wait_mov();
      $display("gating done");
   endtask
   initial begin
      repeat (4) @(negedge clk);
      chk("reset outputs", {mov, pin, brk, spo, data[3:0]}, 8'h20);
      nrst = 1'h1;
      t_ext();
      t_lvl();
      t_step();
      t_keep();
      t_gate();
      end_sim();
   end
endmodule
`default_nettype wire
